// ### verilog/wssc_params.svh
// constants for the single-counter weld stepper
`ifndef WSSC_PARAMS_SVH
`define WSSC_PARAMS_SVH
// ----------------------------------------
// schedule map
// ----------------------------------------
`define WSSC_IDX_W 6
`define WSSC_MAX_IDX 7'h31
`define WSSC_FIRST_IDX 6'h00
`define WSSC_IDX_ONE 7'h01
// ----------------------------------------
// bcd count and reset command
// ----------------------------------------
`define WSSC_CNT_W 16
`define WSSC_CNT_ZERO 16'h0000
`define WSSC_CNT_ONE 16'h0001
`define WSSC_OFF_W 8
`define WSSC_RST_OFF 8'h99
// ----------------------------------------
// timing
// ----------------------------------------
`define WSSC_CLK_KHZ 25000
`define WSSC_SHOW_MS 1000
`define WSSC_BLINK_MS 250
`define WSSC_TMR_W 25
`define WSSC_TMR_ZERO 25'h0000000
`define WSSC_TMR_ONE 25'h0000001
`endif

// ### verilog/wssc_pkg.sv
// types for the single-counter weld stepper
package wssc_pkg;
    typedef enum logic [1:0] {
        WSSC_IDLE = 2'b00,
        WSSC_RD_NEXT = 2'b01,
        WSSC_RD_FIRST = 2'b10,
        WSSC_END = 2'b11
    } wssc_state_t;
endpackage

// ### verilog/wssc_stepper.sv
// single-counter weld stepper: count, step walk, end detect and resets
`timescale 1ns/1ps
`include "wssc_params.svh"

// Function
// - up to fifty single-schedule steps
// - chained schedules shrink usable step count
// - index past 49 gives end of stepper
// - only primary initiation decrements the counter
// - weld count taken from step's first schedule
// - next schedule count 0000 means end
// - manual reset loads first step values
// - reset needs program mode, enter and both data buttons
// - show loaded values briefly after reset
// - direct write of step and count resets
// - reset command schedule reloads first step
// - reset command: zero params, count 0000, off 99
// - enter plus program/operate in program mode clears displayed schedule
// - manual reset accepted with any schedule selected
// - four-digit bcd down-counter up to 9999
// - end message flashes until button or estop
module wssc_stepper #(
    parameter int unsigned SHOW_CYCLES = `WSSC_SHOW_MS * `WSSC_CLK_KHZ,
    parameter int unsigned BLINK_CYCLES = `WSSC_BLINK_MS * `WSSC_CLK_KHZ
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // front panel
    input wire logic i_prog_mode,
    input wire logic i_btn_enter,
    input wire logic i_btn_data_l,
    input wire logic i_btn_data_r,
    input wire logic i_btn_progop,
    input wire logic i_btn_other,
    input wire logic i_estop,
    input wire logic [`WSSC_IDX_W-1:0] i_disp_sched,
    // direct write of last step and last count
    input wire logic i_wr_valid,
    input wire logic [`WSSC_IDX_W-1:0] i_wr_step,
    input wire logic [`WSSC_CNT_W-1:0] i_wr_count,
    // sequencer completion report
    input wire logic i_seq_done,
    input wire logic i_seq_primary,
    input wire logic [`WSSC_IDX_W-1:0] i_seq_last_sched,
    // schedule read port, data taken in the same cycle as the address
    input wire logic [`WSSC_CNT_W-1:0] i_rd_count,
    input wire logic [`WSSC_OFF_W-1:0] i_rd_off,
    input wire logic i_rd_rest_zero,
    output logic [`WSSC_IDX_W-1:0] o_rd_addr,
    // stepper state
    output logic [`WSSC_IDX_W-1:0] o_last_step,
    output logic [`WSSC_CNT_W-1:0] o_last_count,
    output logic o_end_active,
    output logic o_end_flash,
    output logic o_show_loaded,
    // schedule clear request
    output logic o_clear_sched,
    output logic [`WSSC_IDX_W-1:0] o_clear_addr
);
    import wssc_pkg::*;

    // ----------------------------------------
    // bcd decrement
    // ----------------------------------------
    function automatic logic [`WSSC_CNT_W-1:0] bcd_dec(input logic [`WSSC_CNT_W-1:0] v);
        logic [`WSSC_CNT_W-1:0] r;
        logic borrow;
        r = v;
        borrow = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (borrow) begin
                if (r[4*i +: 4] == 4'h0) begin
                    r[4*i +: 4] = 4'h9;
                end else begin
                    r[4*i +: 4] = r[4*i +: 4] - 4'h1;
                    borrow = 1'b0;
                end
            end
        end
        return r;
    endfunction

    // ----------------------------------------
    // registers
    // ----------------------------------------
    wssc_state_t state_q, state_d;
    logic [`WSSC_IDX_W-1:0] step_q, step_d;
    logic [`WSSC_CNT_W-1:0] count_q, count_d;
    logic [`WSSC_IDX_W-1:0] addr_q, addr_d;
    logic [`WSSC_TMR_W-1:0] show_cnt_q, show_cnt_d;
    logic [`WSSC_TMR_W-1:0] blink_cnt_q, blink_cnt_d;
    logic show_q;
    logic flash_q, flash_d;
    logic end_q;
    logic rst_prev_q;
    logic clr_prev_q;
    logic btn_prev_q;
    logic clear_q;
    logic [`WSSC_IDX_W-1:0] clear_addr_q;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire rst_combo = i_prog_mode & i_btn_enter & i_btn_data_l & i_btn_data_r;
    wire rst_evt = rst_combo & ~rst_prev_q;
    wire clr_combo = i_prog_mode & i_btn_enter & i_btn_progop;
    wire clr_evt = clr_combo & ~clr_prev_q;
    wire any_btn = i_btn_enter | i_btn_data_l | i_btn_data_r | i_btn_progop | i_btn_other;
    wire end_clear = (any_btn & ~btn_prev_q) | i_estop;
    wire cnt_evt = i_seq_done & i_seq_primary & (state_q == WSSC_IDLE);
    wire zero_after = (count_q <= `WSSC_CNT_ONE);
    wire [`WSSC_IDX_W:0] next_idx = {1'b0, i_seq_last_sched} + `WSSC_IDX_ONE;
    wire idx_ovf = next_idx > `WSSC_MAX_IDX;
    wire rd_is_reset = i_rd_rest_zero & (i_rd_count == `WSSC_CNT_ZERO)
        & (i_rd_off == `WSSC_RST_OFF);
    wire rd_is_end = ~rd_is_reset & (i_rd_count == `WSSC_CNT_ZERO);
    wire [`WSSC_CNT_W-1:0] count_dec = bcd_dec(count_q);
    wire load_first = (state_q == WSSC_RD_FIRST) & ~i_wr_valid & ~rst_evt;
    wire [`WSSC_TMR_W-1:0] show_init = `WSSC_TMR_W'(SHOW_CYCLES);
    wire [`WSSC_TMR_W-1:0] blink_init = `WSSC_TMR_W'(BLINK_CYCLES);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        step_d = step_q;
        count_d = count_q;
        addr_d = addr_q;
        if (i_wr_valid) begin
            step_d = i_wr_step;
            count_d = i_wr_count;
            state_d = WSSC_IDLE;
        end else if (rst_evt) begin
            addr_d = `WSSC_FIRST_IDX;
            state_d = WSSC_RD_FIRST;
        end else begin
            unique case (state_q)
                WSSC_IDLE: begin
                    if (cnt_evt) begin
                        if (!zero_after) begin
                            count_d = count_dec;
                        end else if (idx_ovf) begin
                            count_d = `WSSC_CNT_ZERO;
                            state_d = WSSC_END;
                        end else begin
                            count_d = `WSSC_CNT_ZERO;
                            addr_d = next_idx[`WSSC_IDX_W-1:0];
                            state_d = WSSC_RD_NEXT;
                        end
                    end
                end
                WSSC_RD_NEXT: begin
                    if (rd_is_reset) begin
                        addr_d = `WSSC_FIRST_IDX;
                        state_d = WSSC_RD_FIRST;
                    end else if (rd_is_end) begin
                        state_d = WSSC_END;
                    end else begin
                        step_d = addr_q;
                        count_d = i_rd_count;
                        state_d = WSSC_IDLE;
                    end
                end
                WSSC_RD_FIRST: begin
                    step_d = addr_q;
                    count_d = i_rd_count;
                    state_d = WSSC_IDLE;
                end
                WSSC_END: begin
                    if (end_clear) begin
                        state_d = WSSC_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // display timers
    // ----------------------------------------
    always_comb begin
        show_cnt_d = show_cnt_q;
        if (load_first) begin
            show_cnt_d = show_init;
        end else if (show_cnt_q != `WSSC_TMR_ZERO) begin
            show_cnt_d = show_cnt_q - `WSSC_TMR_ONE;
        end
        blink_cnt_d = blink_init;
        flash_d = 1'b0;
        if (state_d == WSSC_END) begin
            flash_d = (state_q == WSSC_END) ? flash_q : 1'b1;
            if (state_q == WSSC_END && blink_cnt_q > `WSSC_TMR_ONE) begin
                blink_cnt_d = blink_cnt_q - `WSSC_TMR_ONE;
            end else if (state_q == WSSC_END) begin
                flash_d = ~flash_q;
            end
        end
    end

    // ----------------------------------------
    // flops
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q <= WSSC_IDLE;
            step_q <= `WSSC_FIRST_IDX;
            count_q <= `WSSC_CNT_ZERO;
            addr_q <= `WSSC_FIRST_IDX;
        end else begin
            state_q <= state_d;
            step_q <= step_d;
            count_q <= count_d;
            addr_q <= addr_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            show_cnt_q <= `WSSC_TMR_ZERO;
            blink_cnt_q <= `WSSC_TMR_ZERO;
            show_q <= 1'b0;
            flash_q <= 1'b0;
            end_q <= 1'b0;
        end else begin
            show_cnt_q <= show_cnt_d;
            blink_cnt_q <= blink_cnt_d;
            show_q <= (show_cnt_d != `WSSC_TMR_ZERO);
            flash_q <= flash_d;
            end_q <= (state_d == WSSC_END);
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_prev_q <= 1'b0;
            clr_prev_q <= 1'b0;
            btn_prev_q <= 1'b0;
            clear_q <= 1'b0;
            clear_addr_q <= `WSSC_FIRST_IDX;
        end else begin
            rst_prev_q <= rst_combo;
            clr_prev_q <= clr_combo;
            btn_prev_q <= any_btn;
            clear_q <= clr_evt;
            clear_addr_q <= clr_evt ? i_disp_sched : clear_addr_q;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign o_rd_addr = addr_q;
    assign o_last_step = step_q;
    assign o_last_count = count_q;
    assign o_end_active = end_q;
    assign o_end_flash = flash_q;
    assign o_show_loaded = show_q;
    assign o_clear_sched = clear_q;
    assign o_clear_addr = clear_addr_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    sequence man_reset_s;
        rst_evt && !i_wr_valid;
    endsequence
    sequence reload_s;
        (state_q == WSSC_RD_FIRST) ##1 (o_last_step == `WSSC_FIRST_IDX);
    endsequence

    count_step_down_a: assert property (
        cnt_evt && !zero_after && !i_wr_valid && !rst_evt
        |=> o_last_count == bcd_dec($past(o_last_count)))
        else $error("counter did not step down by one");
    other_init_hold_a: assert property (
        i_seq_done && !i_seq_primary && state_q == WSSC_IDLE && !i_wr_valid && !rst_evt
        |=> $stable(o_last_count) && $stable(o_last_step))
        else $error("non-primary sequence changed the stepper");
    index_overflow_a: assert property (
        cnt_evt && zero_after && idx_ovf && !i_wr_valid && !rst_evt
        |=> ##1 o_end_active)
        else $error("index overflow did not end the stepper");
    manual_reset_a: assert property (
        man_reset_s |=> reload_s)
        else $error("manual reset did not reload first step");
    reset_display_a: assert property (
        man_reset_s ##1 (load_first) |=> o_show_loaded [*3])
        else $error("loaded values not shown after reset");
    direct_write_a: assert property (
        i_wr_valid |=> o_last_step == $past(i_wr_step)
            && o_last_count == $past(i_wr_count) && !o_end_active)
        else $error("direct write not taken");
    reset_cmd_a: assert property (
        state_q == WSSC_RD_NEXT && rd_is_reset && !i_wr_valid && !rst_evt
        |=> reload_s)
        else $error("reset command did not reload");
    empty_sched_end_a: assert property (
        state_q == WSSC_RD_NEXT && rd_is_end && !i_wr_valid && !rst_evt
        |=> ##1 o_end_active && o_end_flash)
        else $error("empty schedule did not end the stepper");
    end_clear_a: assert property (
        state_q == WSSC_END && end_clear && !rst_evt |=> ##1 !o_end_active)
        else $error("end message not cleared");
    clear_sched_a: assert property (
        clr_evt |=> o_clear_sched && o_clear_addr == $past(i_disp_sched) ##1 !o_clear_sched)
        else $error("schedule clear request missing");
endmodule

// ### verification/wssc_sched_model.sv
// schedule memory model answering reads combinationally
`timescale 1ns/1ps
`include "wssc_params.svh"
module wssc_sched_model (
    // read port
    input wire logic [`WSSC_IDX_W-1:0] i_addr,
    output logic [`WSSC_CNT_W-1:0] o_count,
    output logic [`WSSC_OFF_W-1:0] o_off,
    output logic o_rest_zero
);
    logic [`WSSC_CNT_W-1:0] cnt [0:63];
    logic [`WSSC_OFF_W-1:0] off [0:63];
    logic rz [0:63];
    // every schedule starts empty: count 0000, all else cleared
    initial begin
        for (int i = 0; i < 64; i++) begin
            cnt[i] = `WSSC_CNT_ZERO;
            off[i] = 8'h00;
            rz[i] = 1'b1;
        end
    end
    task automatic set(input int a, input logic [15:0] c, input logic [7:0] o, input logic z);
        cnt[a] = c;
        off[a] = o;
        rz[a] = z;
    endtask
    assign o_count = cnt[i_addr];
    assign o_off = off[i_addr];
    assign o_rest_zero = rz[i_addr];
endmodule

// ### verification/tb_wssc_stepper.sv
// self-checking bench for the single-counter weld stepper
`timescale 1ns/1ps
`include "wssc_params.svh"
module tb_wssc_stepper;
    import wssc_pkg::*;
    typedef struct {int k; logic [23:0] v; int due;} wssc_note_t;
    logic i_clk = 1'b0, i_arst_n = 1'b0, i_prog_mode = 1'b0, i_btn_enter = 1'b0;
    logic i_btn_data_l = 1'b0, i_btn_data_r = 1'b0, i_btn_progop = 1'b0, i_btn_other = 1'b0;
    logic i_estop = 1'b0, i_wr_valid = 1'b0, i_seq_done = 1'b0, i_seq_primary = 1'b0;
    logic [5:0] i_disp_sched = 6'h00, i_wr_step = 6'h00, i_seq_last_sched = 6'h00;
    logic [15:0] i_wr_count = 16'h0000, i_rd_count;
    logic [7:0] i_rd_off;
    logic i_rd_rest_zero, o_end_active, o_end_flash, o_show_loaded, o_clear_sched;
    logic [5:0] o_rd_addr, o_last_step, o_clear_addr;
    logic [15:0] o_last_count;
    int cyc = 0, err_total = 0, total_checks = 0;
    wssc_note_t notes[$], cur;
    // ----------------------------------------
    // design and schedule model
    // ----------------------------------------
    wssc_stepper #(.SHOW_CYCLES(5), .BLINK_CYCLES(3)) dut (.i_clk, .i_arst_n, .i_prog_mode,
        .i_btn_enter, .i_btn_data_l, .i_btn_data_r, .i_btn_progop, .i_btn_other, .i_estop,
        .i_disp_sched, .i_wr_valid, .i_wr_step, .i_wr_count, .i_seq_done, .i_seq_primary,
        .i_seq_last_sched, .i_rd_count, .i_rd_off, .i_rd_rest_zero, .o_rd_addr, .o_last_step,
        .o_last_count, .o_end_active, .o_end_flash, .o_show_loaded, .o_clear_sched,
        .o_clear_addr);
    wssc_sched_model mdl (.i_addr(o_rd_addr), .o_count(i_rd_count), .o_off(i_rd_off),
        .o_rest_zero(i_rd_rest_zero));
    always #20 i_clk = ~i_clk;
    always @(posedge i_clk) cyc <= cyc + 1;
    // ----------------------------------------
    // notes, compares and monitor
    // ----------------------------------------
    function automatic logic [23:0] st(logic s, logic e, logic [5:0] a, logic [15:0] c);
        return {s, e, a, c};
    endfunction
    task automatic nt(input int k, input logic [23:0] v, input int n);
        wssc_note_t t;
        t.k = k;
        t.v = v;
        t.due = cyc + 1 + n;
        notes.push_back(t);
    endtask
    task automatic report(input logic [23:0] e, input logic [23:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task automatic cmp_state(input logic [23:0] e);
        report(e, {o_show_loaded, o_end_active, o_last_step, o_last_count});
    endtask
    task automatic cmp_clear(input logic [23:0] e);
        report(e, {17'h00000, o_clear_sched, o_clear_addr});
    endtask
    task automatic cmp_flash(input logic [23:0] e);
        report(e, {17'h00000, o_end_flash, o_rd_addr});
    endtask
    always @(negedge i_clk) begin
        while (notes.size() > 0 && notes[0].due == cyc) begin
            cur = notes.pop_front();
            if (cur.k == 2) cmp_flash(cur.v);
            else if (cur.k == 1) cmp_clear(cur.v);
            else cmp_state(cur.v);
        end
    end
    // ----------------------------------------
    // drivers
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic wr(input logic [5:0] s, input logic [15:0] c);
        nt(0, st(0, 0, s, c), 0);
        i_wr_valid = 1'b1;
        i_wr_step = s;
        i_wr_count = c;
        tick(1);
        i_wr_valid = 1'b0;
        tick(3);
    endtask
    task automatic done(input logic p, input logic [5:0] l);
        i_seq_done = 1'b1;
        i_seq_primary = p;
        i_seq_last_sched = l;
        tick(1);
        i_seq_done = 1'b0;
        tick(8);
    endtask
    task automatic end_off(input int w, input logic [5:0] s);
        nt(0, st(0, 0, s, 16'h0000), 2);
        if (w == 0) i_btn_other = 1'b1;
        else if (w == 1) i_estop = 1'b1;
        else i_btn_enter = 1'b1;
        tick(1);
        {i_btn_other, i_estop, i_btn_enter} = 3'b000;
        tick(4);
    endtask
    function automatic logic [15:0] bcd_dec(input logic [15:0] v);
        logic [15:0] r;
        r = v;
        for (int i = 0; i < 4; i++) begin
            if (r[4*i +: 4] != 4'h0) begin
                r[4*i +: 4] = r[4*i +: 4] - 4'h1;
                return r;
            end
            r[4*i +: 4] = 4'h9;
        end
        return r;
    endfunction
    task automatic wrap_up;
        if (notes.size() != 0) begin
            err_total++;
            $display("Error at %0t: expected %h got %h", $time, 0, notes.size());
        end
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #(40 * 3000);
        err_total++;
        wrap_up();
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        logic [15:0] c;
        logic [7:0] offs [3];
        void'($urandom(75));
        offs = '{8'h00, 8'h98, 8'h99};
        #1;
        mdl.set(0, 16'h0325, 8'h00, 1'b0);
        for (int i = 1; i < 5; i++) mdl.set(i, 16'($urandom % 16'h0999) + 16'h0001, 8'h00, 1'b0);
        mdl.set(5, 16'h0250, 8'h00, 1'b0);
        mdl.set(16, 16'h0010, 8'h00, 1'b0);
        mdl.set(49, 16'h0042, 8'h00, 1'b0);
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        i_arst_n = 1'b1;
        nt(0, st(0, 0, 6'h00, 16'h0000), 0);
        tick(2);
        $display("reset values done");
        for (int k = 0; k < 4; k++) begin
            c = {4'(1 + $urandom % 9), 4'($urandom % 10), 4'($urandom % 10), 4'($urandom % 10)};
            if (k == 0) c = 16'h1000;
            wr(6'h07, c);
            nt(0, st(0, 0, 6'h07, c), 1);
            done(1'b0, 6'h07);
            nt(0, st(0, 0, 6'h07, bcd_dec(c)), 1);
            done(1'b1, 6'h07);
        end
        $display("count down done");
        wr(6'h00, 16'h0001);
        nt(0, st(0, 0, 6'h05, 16'h0250), 2);
        done(1'b1, 6'h04);
        $display("chained step done");
        for (int k = 0; k < 3; k++) begin
            mdl.set(17, 16'h0000, offs[k], 1'b1);
            wr(6'h10, 16'h0001);
            if (k == 2) begin
                nt(0, st(1, 0, 6'h00, 16'h0325), 3);
            end else begin
                nt(0, st(0, 1, 6'h10, 16'h0000), 2);
                nt(2, {17'h00000, 1'b1, 6'h11}, 2);
                nt(2, {17'h00000, 1'b0, 6'h11}, 5);
            end
            done(1'b1, 6'h10);
            if (k != 2) end_off(k, 6'h10);
        end
        $display("end and auto reset done");
        wr(6'h31, 16'h0001);
        nt(0, st(0, 1, 6'h31, 16'h0000), 2);
        done(1'b1, 6'h31);
        end_off(2, 6'h31);
        wr(6'h30, 16'h0001);
        nt(0, st(0, 0, 6'h31, 16'h0042), 2);
        done(1'b1, 6'h30);
        $display("index limit done");
        i_disp_sched = 6'($urandom % 50);
        wr(6'h09, 16'h0005);
        nt(0, st(0, 0, 6'h09, 16'h0005), 2);
        {i_btn_enter, i_btn_data_l, i_btn_data_r} = 3'b111;
        tick(1);
        {i_btn_enter, i_btn_data_l, i_btn_data_r} = 3'b000;
        tick(3);
        {i_prog_mode, i_btn_enter, i_btn_data_l} = 3'b111;
        nt(0, st(0, 0, 6'h09, 16'h0005), 2);
        tick(2);
        i_btn_data_r = 1'b1;
        nt(0, st(1, 0, 6'h00, 16'h0325), 2);
        tick(1);
        {i_btn_enter, i_btn_data_l, i_btn_data_r} = 3'b000;
        tick(8);
        $display("manual reset done");
        i_disp_sched = 6'($urandom % 50);
        {i_btn_enter, i_btn_progop} = 2'b11;
        nt(1, {17'h00000, 1'b1, i_disp_sched}, 0);
        nt(1, {17'h00000, 1'b0, i_disp_sched}, 1);
        tick(1);
        {i_btn_enter, i_btn_progop} = 2'b00;
        tick(4);
        $display("schedule clear done");
        wrap_up();
    end
endmodule
